/* core/fle_pkg.sv */
/*
 Constants for the flash LED enable and fault readback register block.
 Assumes an I2C slave front end elsewhere delivers decoded register strobes.
*/
// Function
// - capture each channel's flash current code into read-only bits [5:0] on dc limit fault.
// - captured code reads 12.5 mA per LSB, 0 to 787.5 mA.
// - enable bit 1 switches second LED output; reset clears it.
// - enable bit 0 switches first LED output; reset clears it.
// - second channel set ignored while first channel already enabled.
// - first channel set ignored while second channel already enabled.
// - fault capture happens only when dc current limit function is enabled.
package fle_pkg;
	localparam logic [7:0] FLE_ADDR_CAP_A = 8'h0D;
	localparam logic [7:0] FLE_ADDR_CAP_B = 8'h0E;
	localparam logic [7:0] FLE_ADDR_ENABLE = 8'h0F;
	localparam int FLE_CODE_W = 6;
	localparam int FLE_EN_A_BIT = 0;
	localparam int FLE_EN_B_BIT = 1;
	localparam logic [5:0] FLE_CODE_RST = 6'h00;
	localparam logic [1:0] FLE_EN_RST = 2'h0;
	localparam logic [7:0] FLE_RD_RST = 8'h00;
	// readback weight in microamps per code step
	localparam int FLE_UA_PER_LSB = 12500;
endpackage

/* core/fle_capture.sv */
/*
 One fault current capture register.
 Assumes the fault input is already synchronised to sys_clk.
*/
`timescale 1ns/1ps
module fle_capture #(
	parameter int CODE_W = fle_pkg::FLE_CODE_W
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// capture source
	input wire logic capture,
	input wire logic [CODE_W-1:0] code,
	// stored code
	output logic [CODE_W-1:0] held_q
);
	import fle_pkg::*;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			held_q <= CODE_W'(FLE_CODE_RST);
		end else if (capture) begin
			held_q <= code;
		end
	end
endmodule

/* core/fle_regs.sv */
/*
 Enable register with interlock and two fault current readback registers.
 Map: two read-only capture words and one read/write enable word; any
 other address reads as zero and swallows writes.
 Assumes a register-level write/read strobe from the I2C slave on sys_clk,
 one single-cycle strobe per transfer, address and data valid with it.
 Assumes an asynchronous dc limit fault level, synchronised here, and a
 limit enable level and present flash codes that already live on sys_clk.
*/
`timescale 1ns/1ps
module fle_regs (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// register port from the serial front end
	input wire logic wr_stb,
	input wire logic rd_stb,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] wr_data,
	output logic [7:0] rd_data_q,
	// analog side
	input wire logic dc_limit_fault,
	input wire logic dc_limit_enable,
	input wire logic [fle_pkg::FLE_CODE_W-1:0] chan_a_flash_code,
	input wire logic [fle_pkg::FLE_CODE_W-1:0] chan_b_flash_code,
	// outputs
	output logic chan_a_output_on,
	output logic chan_b_output_on,
	output logic dc_limit_reached_flag
);
	import fle_pkg::*;

	// fault synchroniser stages and edge memory
	logic sync1_q;
	logic sync2_q;
	logic prev_q;

	// fault status and capture strobe
	logic fault_level;
	logic fault_edge;
	logic fault_rise;

	// codes held by the two readback registers
	logic [FLE_CODE_W-1:0] chan_a_fault_current_code;
	logic [FLE_CODE_W-1:0] chan_b_fault_current_code;

	// address decode
	logic hit_cap_a;
	logic hit_cap_b;
	logic hit_enable;

	// enable write decode and interlock
	logic en_wr;
	logic req_a;
	logic req_b;
	logic late_a;
	logic late_b;
	logic write_dropped;
	logic en_take;

	// enable register, one flop per channel, and next values
	logic en_a_q;
	logic en_b_q;
	logic en_a_d;
	logic en_b_d;

	// readback words and the selected one
	logic [7:0] word_cap_a;
	logic [7:0] word_cap_b;
	logic [7:0] word_enable;
	logic [7:0] rd_mux;

	// fault level from the analog domain; first stage feeds only the second
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			sync1_q <= 1'b0;
		end else begin
			sync1_q <= dc_limit_fault;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			sync2_q <= 1'b0;
		end else begin
			sync2_q <= sync1_q;
		end
	end

	// last synchronised level, to find the rising edge
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= sync2_q;
		end
	end

	// the status only exists while the limit function is switched on
	assign fault_level = sync2_q && dc_limit_enable;
	assign fault_edge = sync2_q && !prev_q;
	// a fault that stays high does not recapture later code changes
	assign fault_rise = fault_edge && dc_limit_enable;

	fle_capture #(
		.CODE_W(FLE_CODE_W)
	) u_cap_a (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.capture(fault_rise),
		.code(chan_a_flash_code),
		.held_q(chan_a_fault_current_code)
	);

	fle_capture #(
		.CODE_W(FLE_CODE_W)
	) u_cap_b (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.capture(fault_rise),
		.code(chan_b_flash_code),
		.held_q(chan_b_fault_current_code)
	);

	assign hit_cap_a = (reg_addr == FLE_ADDR_CAP_A);
	assign hit_cap_b = (reg_addr == FLE_ADDR_CAP_B);
	assign hit_enable = (reg_addr == FLE_ADDR_ENABLE);

	assign en_wr = wr_stb && hit_enable;
	assign req_a = wr_data[FLE_EN_A_BIT];
	assign req_b = wr_data[FLE_EN_B_BIT];

	// a channel being switched on while the other one already runs
	assign late_a = req_a && !en_a_q && en_b_q;
	assign late_b = req_b && !en_b_q && en_a_q;
	// both-on from all-off passes, as neither channel is on yet
	assign write_dropped = late_a || late_b;
	// an ignored write keeps the whole register, clears included
	assign en_take = en_wr && !write_dropped;

	always_comb begin
		en_a_d = en_a_q;
		if (en_take) begin
			en_a_d = req_a;
		end
	end

	always_comb begin
		en_b_d = en_b_q;
		if (en_take) begin
			en_b_d = req_b;
		end
	end

	// reset leaves both channels dark
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			en_a_q <= FLE_EN_RST[FLE_EN_A_BIT];
		end else begin
			en_a_q <= en_a_d;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			en_b_q <= FLE_EN_RST[FLE_EN_B_BIT];
		end else begin
			en_b_q <= en_b_d;
		end
	end

	// outputs come straight from flops loaded at the same edge as the register
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			chan_a_output_on <= FLE_EN_RST[FLE_EN_A_BIT];
		end else begin
			chan_a_output_on <= en_a_d;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			chan_b_output_on <= FLE_EN_RST[FLE_EN_B_BIT];
		end else begin
			chan_b_output_on <= en_b_d;
		end
	end

	// status follows the level, so it drops as soon as the limit is switched off
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			dc_limit_reached_flag <= 1'b0;
		end else begin
			dc_limit_reached_flag <= fault_level;
		end
	end

	// readback words; reserved bits are tied low and writes never reach them
	assign word_cap_a = {2'h0, chan_a_fault_current_code};
	assign word_cap_b = {2'h0, chan_b_fault_current_code};
	assign word_enable = {6'h00, en_b_q, en_a_q};

	// unmapped addresses read as zero
	always_comb begin
		rd_mux = 8'h00;
		if (hit_cap_a) begin
			rd_mux = word_cap_a;
		end else if (hit_cap_b) begin
			rd_mux = word_cap_b;
		end else if (hit_enable) begin
			rd_mux = word_enable;
		end
	end

	// read data holds until the next read strobe
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rd_data_q <= FLE_RD_RST;
		end else if (rd_stb) begin
			rd_data_q <= rd_mux;
		end
	end
endmodule

/* tb/fle_regs_sva.sv */
/* assertions on the fle_regs ports; bound to every fle_regs instance */
`timescale 1ns/1ps
module fle_regs_sva (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// register port
	input wire logic wr_stb,
	input wire logic rd_stb,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] wr_data,
	input wire logic [7:0] rd_data_q,
	// analog side and outputs
	input wire logic dc_limit_fault,
	input wire logic dc_limit_enable,
	input wire logic dc_limit_reached_flag,
	input wire logic chan_a_output_on,
	input wire logic chan_b_output_on
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	wire wen = wr_stb && reg_addr == 8'h0F;
	wire a_on = chan_a_output_on;
	wire b_on = chan_b_output_on;
	sequence off_wr_s; wen && !a_on && !b_on; endsequence
	b_from_off_a: assert property (off_wr_s |=> b_on == $past(wr_data[1]))
		else $error("chan b enable wrong");
	a_from_off_a: assert property (off_wr_s |=> a_on == $past(wr_data[0]))
		else $error("chan a enable wrong");
	b_locked_a: assert property (wen && a_on && !b_on && wr_data[1] |=> !b_on)
		else $error("chan b set while a on");
	a_locked_a: assert property (wen && b_on && !a_on && wr_data[0] |=> !a_on)
		else $error("chan a set while b on");
	limit_gated_a: assert property (!dc_limit_enable [*2] |-> !dc_limit_reached_flag)
		else $error("flag without enable");
	flag_follows_a: assert property ((dc_limit_fault && dc_limit_enable) [*3] |=> dc_limit_reached_flag)
		else $error("flag missing with fault and enable");
	reserved_zero_a: assert property (rd_stb && reg_addr inside {8'h0D, 8'h0E} |=>
		rd_data_q[7:6] == 2'h0) else $error("reserved bits set");
	ro_write_a: assert property (wr_stb && reg_addr != 8'h0F |=> $stable({a_on, b_on}))
		else $error("enables moved");
	unmapped_zero_a: assert property (rd_stb && reg_addr > 8'h0F |=> rd_data_q == 8'h00)
		else $error("unmapped read not zero");
endmodule
bind fle_regs fle_regs_sva sva_u (
	.sys_clk(sys_clk),
	.nrst(nrst),
	.wr_stb(wr_stb),
	.rd_stb(rd_stb),
	.reg_addr(reg_addr),
	.wr_data(wr_data),
	.rd_data_q(rd_data_q),
	.dc_limit_fault(dc_limit_fault),
	.dc_limit_enable(dc_limit_enable),
	.dc_limit_reached_flag(dc_limit_reached_flag),
	.chan_a_output_on(chan_a_output_on),
	.chan_b_output_on(chan_b_output_on)
);

/* tb/fle_host.sv */
/* register host model; strobes last one cycle, driven on falling edges */
`timescale 1ns/1ps
module fle_host (
	// clock
	input wire logic sys_clk,
	// register port
	output logic wr_stb = 1'b0,
	output logic rd_stb = 1'b0,
	output logic [7:0] reg_addr = 8'h00,
	output logic [7:0] wr_data = 8'h00
);
	// released lines flip so a stale value is never mistaken for a live one
	task wr(input logic [7:0] a, d);
		@(negedge sys_clk);
		reg_addr = a;
		wr_data = d;
		wr_stb = 1'b1;
		@(negedge sys_clk);
		wr_stb = 1'b0;
		reg_addr = ~a;
		wr_data = ~d;
	endtask
	task rd(input logic [7:0] a);
		@(negedge sys_clk);
		reg_addr = a;
		rd_stb = 1'b1;
		@(negedge sys_clk);
		rd_stb = 1'b0;
		reg_addr = ~a;
	endtask
endmodule

/* tb/flash_led_enable_and_fault_readback_test.sv */
/* self-checking bench for fle_regs; host model drives the register port */
`timescale 1ns/1ps
module flash_led_enable_and_fault_readback_test;
	import fle_pkg::*;
	logic sys_clk = 1'b0, nrst = 1'b0, flt = 1'b0, en = 1'b0;
	logic [5:0] ca = 6'h14, cb = 6'h3C;
	wire wr_stb, rd_stb, a_on, b_on, flag;
	wire [7:0] reg_addr, wr_data, rd_data_q;
	int err_total = 0, n_compared = 0;
	initial forever #20 sys_clk = ~sys_clk;
	fle_host host_u (.sys_clk, .wr_stb, .rd_stb, .reg_addr, .wr_data);
	fle_regs dut_u (.sys_clk, .nrst, .wr_stb, .rd_stb, .reg_addr, .wr_data, .rd_data_q,
		.dc_limit_fault(flt), .dc_limit_enable(en), .chan_a_flash_code(ca),
		.chan_b_flash_code(cb), .chan_a_output_on(a_on), .chan_b_output_on(b_on),
		.dc_limit_reached_flag(flag));
	task chk(string n, logic [7:0] s, e);
		n_compared++;
		if (s !== e) begin
			err_total++;
			$display("unexpected %s exp %h seen %h", n, e, s);
		end
	endtask
	task rdc(logic [7:0] a, e);
		host_u.rd(a);
		chk("rd_data_q", rd_data_q, e);
	endtask
	task print_verdict;
		if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (2) @(negedge sys_clk);
		nrst = 1'b1;
		rdc(8'h0F, 8'h00);
		host_u.wr(8'h0F, 8'h01);
		host_u.wr(8'h0F, 8'h03);
		rdc(8'h0F, 8'h01);
		chk("outputs", {b_on, a_on}, 8'h01);
		host_u.wr(8'h0F, 8'h00);
		host_u.wr(8'h0F, 8'h02);
		host_u.wr(8'h0F, 8'h01);
		rdc(8'h0F, 8'h02);
		chk("outputs", {b_on, a_on}, 8'h02);
		host_u.wr(8'h0F, 8'h00);
		host_u.wr(8'h0F, 8'h03);
		chk("outputs", {b_on, a_on}, 8'h03);
		nrst = 1'b0;
		@(negedge sys_clk);
		chk("outputs", {b_on, a_on}, 8'h00);
		nrst = 1'b1;
		rdc(8'h0F, 8'h00);
		host_u.wr(8'h0F, 8'h03);
		host_u.wr(8'h0D, 8'hFF);
		host_u.wr(8'h0E, 8'hFF);
		rdc(8'h0F, 8'h03);
		rdc(8'h0D, 8'h00);
		rdc(8'h20, 8'h00);
		flt = 1'b1;
		repeat (6) @(negedge sys_clk);
		chk("flag", flag, 8'h00);
		rdc(8'h0E, 8'h00);
		flt = 1'b0;
		en = 1'b1;
		repeat (3) @(negedge sys_clk);
		flt = 1'b1;
		for (int i = 0; i < 8 && flag !== 1'b1; i++) @(negedge sys_clk);
		chk("flag", flag, 8'h01);
		repeat (2) @(negedge sys_clk);
		cb = 6'h01;
		rdc(8'h0E, 8'(750000 / FLE_UA_PER_LSB));
		rdc(8'h0D, 8'h14);
		en = 1'b0;
		@(negedge sys_clk);
		chk("flag", flag, 8'h00);
		print_verdict();
	end
endmodule
